/* rtl/ora_map.vh */
`ifndef ORA_MAP_VH
`define ORA_MAP_VH

// channel and route geometry
`define ORA_NCH        6
`define ORA_NRT        3
`define ORA_NRTE       18
`define ORA_CW         3
`define ORA_RW         5
`define ORA_DW         16
`define ORA_SW         20
`define ORA_AW         12

// register byte addresses
`define ORA_A_CTRL     12'h000
`define ORA_A_IST      12'h004
`define ORA_A_IMSK     12'h008
`define ORA_A_OVF      12'h010
`define ORA_A_RT_TAG   3'h1
`define ORA_F_CFG      2'h0
`define ORA_F_AMP      2'h1
`define ORA_F_PHS      2'h2

// field layout and reset values
`define ORA_F_REN      0
`define ORA_F_SRC_LO   1
`define ORA_F_CLAMP    16
`define ORA_SRC_NONE   3'h7
`define ORA_AMP_RST    16'h0000
`define ORA_PHS_RST    16'h0000
`define ORA_CNT_MAX    16'hFFFF
`define ORA_CNT_ONE    16'h0001

// arithmetic scaling: trig in q1.15, amplitude in q2.14, phase as turn fraction
`define ORA_TRIG_SH    15
`define ORA_AMP_SH     14
`define ORA_QTURN      16'h4000
`define ORA_HALF       16'h8000
`define ORA_SIN_SH     13
`define ORA_TRIG_MAX   17'h07FFF
`define ORA_POS_MAX    20'h07FFF
`define ORA_NEG_MIN    20'hF8000
`define ORA_SAT_POS    16'h7FFF
`define ORA_SAT_NEG    16'h8000

// added latency of the summing path, one sample per clock
`define ORA_LAT_NS     26
`define ORA_SPS_PER_NS 2
`define ORA_EXTRA_LAT  (`ORA_LAT_NS * `ORA_SPS_PER_NS)
`define ORA_PIPE       3
`define ORA_RING       (`ORA_EXTRA_LAT - `ORA_PIPE)
`define ORA_PW         6

`endif

/* rtl/ora_route.v */
`timescale 1ns/1ps
`include "ora_map.vh"

module ora_route (
   input  wire                clk,
   input  wire                reset,
   input  wire                on,
   input  wire [`ORA_DW-1:0]  src_i,
   input  wire [`ORA_DW-1:0]  src_q,
   input  wire [`ORA_DW-1:0]  amp,
   input  wire [`ORA_DW-1:0]  phase,
   output reg  [`ORA_SW-1:0]  add_i,
   output reg  [`ORA_SW-1:0]  add_q
);

   // parabolic sine of a turn fraction; the 16-bit phase wraps by itself
   function [15:0] sin_q15;
      input [15:0] p;
      reg   [29:0] pr;
      reg   [16:0] v;
      begin
         pr = {15'h0, p[14:0]} * (30'h8000 - {15'h0, p[14:0]});
         v  = pr[29:`ORA_SIN_SH];
         if (v > `ORA_TRIG_MAX)
            v = `ORA_TRIG_MAX;
         sin_q15 = p[15] ? (16'h0 - v[15:0]) : v[15:0];
      end
   endfunction

   wire signed [15:0] c_v = sin_q15(phase + `ORA_QTURN);
   wire signed [15:0] s_v = sin_q15(phase);
   wire signed [15:0] si  = src_i;
   wire signed [15:0] sq  = src_q;
   wire signed [32:0] x_i = si * c_v - sq * s_v;
   wire signed [32:0] x_q = si * s_v + sq * c_v;

   reg signed [17:0]  p_i;
   reg signed [17:0]  p_q;
   reg signed [15:0]  a1;
   reg                on1;

   wire signed [35:0] y_i = p_i * a1;
   wire signed [35:0] y_q = p_q * a1;

   // stage one rotates, stage two scales; a disabled route adds zero
   always @(posedge clk) begin
      if (reset) begin
         p_i   <= 18'h0;
         p_q   <= 18'h0;
         a1    <= `ORA_AMP_RST;
         on1   <= 1'b0;
         add_i <= {`ORA_SW{1'b0}};
         add_q <= {`ORA_SW{1'b0}};
      end else begin
         p_i   <= x_i[32:`ORA_TRIG_SH]; // [RL16] [RL15]
         p_q   <= x_q[32:`ORA_TRIG_SH]; // [RL16]
         a1    <= amp;
         on1   <= on;
         add_i <= on1 ? y_i[`ORA_AMP_SH+`ORA_SW-1:`ORA_AMP_SH] : {`ORA_SW{1'b0}}; // [RL16]
         add_q <= on1 ? y_q[`ORA_AMP_SH+`ORA_SW-1:`ORA_AMP_SH] : {`ORA_SW{1'b0}};
      end
   end

endmodule

/* rtl/ora_top.v */
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ora_map.vh"

// Operation
// RL1 - three routes add onto each channel
// RL2 - each route: enable, source, amplitude, phase
// RL3 - only waveform samples travel through routes
// RL4 - one source may feed many channels
// RL5 - total equals own plus enabled routes
// RL6 - all routing done digitally before converter
// RL7 - readable per-channel overflow counter
// RL8 - after first overflow, clamp to full scale
// RL9 - amplitude and phase are 16-bit words
// RL10 - channel router enable turns adding on
// RL11 - route enable includes route in sum
// RL12 - source field picks source channel index
// RL13 - software avoids duplicate sources per channel
// RL14 - own channel as source is rejected
// RL15 - phase wraps modulo one full turn
// RL16 - rotate source pair, scale, then add
// RL17 - router adds fixed 52-sample latency
// RL18 - disabled router passes own signal straight
module ora_top (
   input  wire                      clk,
   input  wire                      reset,
   input  wire [`ORA_AW-1:0]        addr,
   input  wire [31:0]               wdata,
   input  wire                      wr,
   input  wire                      rd,
   output reg  [31:0]               rdata,
   output reg                       irq,
   input  wire [`ORA_NCH*16-1:0]    in_i,
   input  wire [`ORA_NCH*16-1:0]    in_q,
   output reg  [`ORA_NCH*16-1:0]    out_i,
   output reg  [`ORA_NCH*16-1:0]    out_q
);

   // route register block: upper bits tag it, [8:4] the route, [3:2] the field
   function rt_sel;
      input [`ORA_AW-1:0] a;
      begin
         rt_sel = (a[11:9] == `ORA_A_RT_TAG) &&
                  (a[8:4] < `ORA_NRTE) &&
                  (a[1:0] == 2'h0);
      end
   endfunction

   // overflow counter block, one word per channel
   function ovf_sel;
      input [`ORA_AW-1:0] a;
      input integer       ch;
      begin
         ovf_sel = (a == `ORA_A_OVF + ch[9:0] * 4);
      end
   endfunction

   // fits the wide sum to the converter word, clamped once armed
   function [15:0] fit16;
      input [`ORA_SW-1:0] s;
      input               cl;
      begin
         if (cl && ($signed(s) > $signed(`ORA_POS_MAX)))
            fit16 = `ORA_SAT_POS;
         else if (cl && ($signed(s) < $signed(`ORA_NEG_MIN)))
            fit16 = `ORA_SAT_NEG;
         else
            fit16 = s[15:0];
      end
   endfunction

   // a source must name an existing channel other than the route's own
   function src_valid;
      input [`ORA_CW-1:0] s;
      input integer       own;
      begin
         src_valid = (s < `ORA_NCH) && (s != own);
      end
   endfunction

   // channel that owns a route index; the quotient is cut to a channel number
   function [`ORA_CW-1:0] route_chan;
      input [`ORA_RW-1:0] idx;
      reg   [31:0]        q;
      begin
         q          = idx / `ORA_NRT;
         route_chan = q[`ORA_CW-1:0];
      end
   endfunction

   // software-visible state
   reg  [`ORA_NCH-1:0]   router_en;
   reg  [`ORA_NCH-1:0]   ist;
   reg  [`ORA_NCH-1:0]   imsk;
   reg  [`ORA_NCH-1:0]   clamp;
   reg  [15:0]           ovf_cnt [0:`ORA_NCH-1];
   reg  [`ORA_NRTE-1:0]  rt_en;
   reg  [`ORA_CW-1:0]    rt_src  [0:`ORA_NRTE-1];
   reg  [15:0]           rt_amp  [0:`ORA_NRTE-1];
   reg  [15:0]           rt_phs  [0:`ORA_NRTE-1];
   reg  [`ORA_PW-1:0]    ptr;
   reg  [31:0]           rd_val;
   reg  [`ORA_NCH-1:0]   next_ist;

   wire [`ORA_NCH-1:0]   ovf_ev;
   wire [`ORA_RW-1:0]    w_idx = addr[8:4];
   wire [`ORA_CW-1:0]    w_src = wdata[`ORA_F_SRC_LO+`ORA_CW-1:`ORA_F_SRC_LO];
   wire [`ORA_CW-1:0]    w_own = route_chan(w_idx);
   wire                  w_rt  = wr && rt_sel(addr);
   wire                  src_ok = src_valid(w_src, w_own);
   wire                  ist_rd = rd && (addr == `ORA_A_IST);
   // one loop index per process, so no variable has two drivers
   integer               n;
   integer               m;
   integer               j;

   // sticky overflow events; a read clears, an event in the same cycle wins
   always @* begin
      next_ist = (ist_rd ? {`ORA_NCH{1'b0}} : ist) | ovf_ev;
   end

   // read mux; unmapped words read as zero
   always @* begin
      rd_val = 32'h0;
      if (addr == `ORA_A_CTRL)
         rd_val[`ORA_NCH-1:0] = router_en;
      else if (addr == `ORA_A_IST)
         rd_val[`ORA_NCH-1:0] = ist;
      else if (addr == `ORA_A_IMSK)
         rd_val[`ORA_NCH-1:0] = imsk;
      else if (rt_sel(addr)) begin
         case (addr[3:2])
            `ORA_F_CFG: begin
               rd_val[`ORA_F_REN] = rt_en[w_idx];
               rd_val[`ORA_F_SRC_LO+`ORA_CW-1:`ORA_F_SRC_LO] = rt_src[w_idx];
            end
            `ORA_F_AMP: rd_val[15:0] = rt_amp[w_idx];
            `ORA_F_PHS: rd_val[15:0] = rt_phs[w_idx];
            default:    rd_val = 32'h0;
         endcase
      end else begin
         for (n = 0; n < `ORA_NCH; n = n + 1) begin
            if (ovf_sel(addr, n)) begin
               rd_val[15:0] = ovf_cnt[n]; // [RL7]
               rd_val[`ORA_F_CLAMP] = clamp[n];
            end
         end
      end
   end

   // register file, overflow bookkeeping and interrupt
   always @(posedge clk) begin
      if (reset) begin
         router_en <= {`ORA_NCH{1'b0}};
         ist       <= {`ORA_NCH{1'b0}};
         imsk      <= {`ORA_NCH{1'b0}};
         rt_en     <= {`ORA_NRTE{1'b0}};
         rdata     <= 32'h0;
         irq       <= 1'b0;
         for (m = 0; m < `ORA_NRTE; m = m + 1) begin
            rt_src[m] <= `ORA_SRC_NONE;
            rt_amp[m] <= `ORA_AMP_RST;
            rt_phs[m] <= `ORA_PHS_RST;
         end
      end else begin
         ist   <= next_ist;
         irq   <= |(next_ist & imsk);
         rdata <= rd ? rd_val : 32'h0;
         if (wr && (addr == `ORA_A_CTRL))
            router_en <= wdata[`ORA_NCH-1:0]; // [RL10]
         if (wr && (addr == `ORA_A_IMSK))
            imsk <= wdata[`ORA_NCH-1:0];
         if (w_rt) begin
            case (addr[3:2])
               `ORA_F_CFG: begin
                  rt_en[w_idx] <= wdata[`ORA_F_REN]; // [RL11] [RL2]
                  // a source naming the route's own channel is refused
                  if (src_ok)
                     rt_src[w_idx] <= w_src; // [RL14] [RL12]
               end
               `ORA_F_AMP: rt_amp[w_idx] <= wdata[15:0]; // [RL9]
               `ORA_F_PHS: rt_phs[w_idx] <= wdata[15:0]; // [RL9] [RL15]
               default: ;
            endcase
         end
      end
   end

   // overflow counters and clamp arm; a clearing write meeting a fresh overflow leaves the count at one and the clamp armed
   always @(posedge clk) begin
      if (reset) begin
         clamp <= {`ORA_NCH{1'b0}};
         for (j = 0; j < `ORA_NCH; j = j + 1)
            ovf_cnt[j] <= 16'h0;
      end else begin
         for (j = 0; j < `ORA_NCH; j = j + 1) begin
            if (ovf_ev[j]) begin
               // count saturates rather than wrapping back to a clean look
               if (wr && ovf_sel(addr, j))
                  ovf_cnt[j] <= `ORA_CNT_ONE;
               else if (ovf_cnt[j] != `ORA_CNT_MAX)
                  ovf_cnt[j] <= ovf_cnt[j] + `ORA_CNT_ONE; // [RL7]
               clamp[j] <= 1'b1; // [RL8]
            end else if (wr && ovf_sel(addr, j)) begin
               ovf_cnt[j] <= 16'h0;
               clamp[j]   <= 1'b0;
            end
         end
      end
   end

   // shared delay ring pointer; runs always so toggling the router is clean
   always @(posedge clk) begin
      if (reset)
         ptr <= {`ORA_PW{1'b0}};
      else if (ptr == `ORA_RING - 1)
         ptr <= {`ORA_PW{1'b0}};
      else
         ptr <= ptr + 1'b1;
   end

   // per-channel datapath; only sample buses cross channels, no marker data
   genvar c, r;
   generate
      for (c = 0; c < `ORA_NCH; c = c + 1) begin : g_ch
         wire [`ORA_NRT*`ORA_SW-1:0] add_i;
         wire [`ORA_NRT*`ORA_SW-1:0] add_q;
         reg  [15:0]                 o1_i;
         reg  [15:0]                 o1_q;
         reg  [15:0]                 o2_i;
         reg  [15:0]                 o2_q;
         reg  [`ORA_SW-1:0]          sum_i;
         reg  [`ORA_SW-1:0]          sum_q;
         reg  [31:0]                 ring [0:`ORA_RING-1];

         for (r = 0; r < `ORA_NRT; r = r + 1) begin : g_rt
            wire [`ORA_CW-1:0] sel = rt_src[c*`ORA_NRT+r];
            wire               ok  = src_valid(sel, c); // [RL14]
            wire               on  = ok && rt_en[c*`ORA_NRT+r] && router_en[c];
            wire [15:0]        s_i = ok ? in_i[sel*16 +: 16] : 16'h0; // [RL3] [RL4]
            wire [15:0]        s_q = ok ? in_q[sel*16 +: 16] : 16'h0; // [RL12]

            ora_route u_route (
               .clk   (clk),
               .reset (reset),
               .on    (on),
               .src_i (s_i),
               .src_q (s_q),
               .amp   (rt_amp[c*`ORA_NRT+r]),
               .phase (rt_phs[c*`ORA_NRT+r]),
               .add_i (add_i[r*`ORA_SW +: `ORA_SW]),
               .add_q (add_q[r*`ORA_SW +: `ORA_SW])
            ); // [RL1] [RL2]
         end

         // overflow is judged on the full-width sum, before any clamp
         assign ovf_ev[c] = router_en[c] &&
            (($signed(sum_i) > $signed(`ORA_POS_MAX)) ||
             ($signed(sum_i) < $signed(`ORA_NEG_MIN)) ||
             ($signed(sum_q) > $signed(`ORA_POS_MAX)) ||
             ($signed(sum_q) < $signed(`ORA_NEG_MIN))); // [RL7]

         // own samples wait two cycles to meet the route outputs
         always @(posedge clk) begin
            if (reset) begin
               o1_i  <= 16'h0;
               o1_q  <= 16'h0;
               o2_i  <= 16'h0;
               o2_q  <= 16'h0;
               sum_i <= {`ORA_SW{1'b0}};
               sum_q <= {`ORA_SW{1'b0}};
            end else begin
               o1_i  <= in_i[c*16 +: 16];
               o1_q  <= in_q[c*16 +: 16];
               o2_i  <= o1_i;
               o2_q  <= o1_q;
               sum_i <= {{(`ORA_SW-16){o2_i[15]}}, o2_i} + add_i[0 +: `ORA_SW] +
                        add_i[`ORA_SW +: `ORA_SW] + add_i[2*`ORA_SW +: `ORA_SW]; // [RL5]
               sum_q <= {{(`ORA_SW-16){o2_q[15]}}, o2_q} + add_q[0 +: `ORA_SW] +
                        add_q[`ORA_SW +: `ORA_SW] + add_q[2*`ORA_SW +: `ORA_SW]; // [RL5]
            end
         end

         // ring holds the fitted sum; no reset, it is flushed by use
         always @(posedge clk) begin
            ring[ptr] <= {fit16(sum_i, clamp[c]), fit16(sum_q, clamp[c])}; // [RL8] [RL17]
         end

         // router on takes the long summed path, off the bare own sample
         always @(posedge clk) begin
            if (reset) begin
               out_i[c*16 +: 16] <= 16'h0;
               out_q[c*16 +: 16] <= 16'h0;
            end else if (router_en[c]) begin
               out_i[c*16 +: 16] <= ring[ptr][31:16]; // [RL17] [RL6]
               out_q[c*16 +: 16] <= ring[ptr][15:0];
            end else begin
               out_i[c*16 +: 16] <= in_i[c*16 +: 16]; // [RL18] [RL10]
               out_q[c*16 +: 16] <= in_q[c*16 +: 16];
            end
         end
      end
   endgenerate

endmodule

/* tb/ora_dac_model.sv */
`timescale 1ns/1ps

// converter of channel 0: takes one code a clock and flags full-scale codes
module ora_dac_model (
   input  wire logic [15:0] code_i,
   input  wire logic        clk,
   output logic [15:0]      last_i,
   output logic             full
);
   // only digital codes arrive here, after all routing and summing
   always @(posedge clk) begin
      last_i <= code_i;
      full   <= (code_i == 16'h7FFF) || (code_i == 16'h8000);
   end
endmodule

/* tb/ora_top_props.sv */
`timescale 1ns/1ps
`include "ora_map.vh"

module ora_top_props (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        irq,
   input wire logic [95:0] in_i,
   input wire logic [95:0] in_q,
   input wire logic [95:0] out_i,
   input wire logic [95:0] out_q
);
   logic [5:0] ctl_s;
   logic [5:0] msk_s;
   logic [6:0] quiet;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // shadow enables; quiet saturates only once the summing pipeline has surely drained
   always @(posedge clk) begin
      if (reset) begin
         ctl_s <= 6'h00;
         msk_s <= 6'h00;
         quiet <= 7'h00;
      end else begin
         if (wr && addr == `ORA_A_CTRL) ctl_s <= wdata[5:0];
         if (wr && addr == `ORA_A_IMSK) msk_s <= wdata[5:0];
         quiet <= (ctl_s != 6'h00) ? 7'h00 : (quiet[6] ? quiet : quiet + 7'h01);
      end
   end
   rd_idle_zero_a: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   ctrl_readback_a: assert property (
      wr && addr == `ORA_A_CTRL ##2 rd && addr == `ORA_A_CTRL
      |=> rdata == {26'h0, $past(wdata[5:0], 3)})
      else $error("router enables read back wrong");
   own_src_a: assert property (
      wr && addr == 12'h200 && wdata[3:1] == 3'h0 ##2 rd && addr == 12'h200
      |=> rdata[3:1] != 3'h0)
      else $error("route accepted its own channel as source");
   status_quiet_a: assert property (
      quiet[6] && rd && addr == `ORA_A_IST ##2 rd && addr == `ORA_A_IST
      |=> rdata == 32'h0)
      else $error("status not cleared by read");
   irq_masked_a: assert property (msk_s == 6'h00 ##1 msk_s == 6'h00 |-> !irq)
      else $error("interrupt high with all sources masked");
   unmapped_read_a: assert property (rd && addr == 12'h100 |=> rdata == 32'h0)
      else $error("unmapped address read non-zero");
   ovf_layout_a: assert property (
      rd && addr == `ORA_A_OVF |=> rdata[31:17] == 15'h0)
      else $error("overflow word upper bits set");
   bypass_a: assert property (
      quiet[6] |-> out_i == $past(in_i) && out_q == $past(in_q))
      else $error("router off but output not the input one sample later");
endmodule

bind ora_top ora_top_props u_props (
   .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .irq(irq), .in_i(in_i), .in_q(in_q), .out_i(out_i), .out_q(out_q));

/* tb/ora_top_tb_top.sv */
`timescale 1ns/1ps
`include "ora_map.vh"

module ora_top_tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        irq;
   logic [95:0] in_i = 96'h0;
   logic [95:0] in_q = 96'h0;
   logic [95:0] out_i;
   logic [95:0] out_q;
   logic        dac_full;
   logic [31:0] v;
   logic [31:0] w;
   logic [95:0] pi;
   integer      si [0:3];
   integer      sq [0:3];
   integer      fail_count = 0;
   integer      comparisons = 0;
   integer      seed = 4;
   integer      n;
   integer      k;
   // register script: write flag, address, data or expected read value
   logic [44:0] seq [0:17] = '{{1'b0, 12'h000, 32'h0}, {1'b0, 12'h010, 32'h0},
      {1'b0, 12'h200, 32'hE}, {1'b1, 12'h200, 32'h1}, {1'b0, 12'h200, 32'hF},
      {1'b1, 12'h200, 32'h3}, {1'b0, 12'h200, 32'h3}, {1'b1, 12'h204, 32'h4000},
      {1'b0, 12'h204, 32'h4000}, {1'b0, 12'h100, 32'h0}, {1'b1, 12'h210, 32'h5},
      {1'b1, 12'h214, 32'h2000}, {1'b1, 12'h218, 32'h4000}, {1'b0, 12'h218, 32'h4000},
      {1'b1, 12'h290, 32'h3}, {1'b1, 12'h294, 32'hC000}, {1'b1, 12'h000, 32'h9},
      {1'b0, 12'h000, 32'h9}};

   always #50 clk = ~clk;

   ora_top dut (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .in_i(in_i), .in_q(in_q), .out_i(out_i), .out_q(out_q));
   ora_dac_model u_dac (.code_i(out_i[15:0]), .clk(clk), .last_i(), .full(dac_full));

   task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // sine and cosine are approximated in the design, so sums get a margin
   task automatic near(input string name, input logic [15:0] seen, input integer exp);
      integer d;
      d = $signed(seen) - exp;
      if (d <= 400 && d >= -400) check(name, seen, seen);
      else check(name, seen, exp[15:0]);
   endtask

   // a spare cycle after each strobe keeps one assignment per time step
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask

   task automatic stop_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // router off after reset: random samples must come straight through
      for (n = 0; n < 20; n++) begin
         pi = {$random(seed), $random(seed), $random(seed)};
         in_i <= pi;
         in_q <= ~pi;
         @(posedge clk);
         #1;
         check("bypass_i", out_i, pi);
         check("bypass_q", out_q, ~pi);
      end
      // quiet inputs so that enabling the router cannot overflow by chance
      in_i <= 96'h0;
      in_q <= 96'h0;
      // distinct sources per channel, ch1 shared by ch0 and ch3
      for (k = 0; k < 18; k++) begin
         if (seq[k][44]) wr_reg(seq[k][43:32], seq[k][31:0]);
         else begin
            rd_reg(seq[k][43:32], v);
            check($sformatf("reg %h", seq[k][43:32]), v, seq[k][31:0]);
         end
      end
      for (k = 0; k < 3; k++) begin
         for (n = 0; n < 4; n++) begin
            si[n] = 2048 + ($random(seed) & 2047);
            sq[n] = 2048 + ($random(seed) & 2047);
            in_i[n*16 +: 16] <= si[n][15:0];
            in_q[n*16 +: 16] <= sq[n][15:0];
         end
         repeat (60) @(posedge clk);
         #1;
         near("sum0_i", out_i[15:0], si[0] + si[1] - sq[2] / 2);
         near("sum0_q", out_q[15:0], sq[0] + sq[1] + si[2] / 2);
         near("sum3_i", out_i[63:48], si[3] - si[1]);
         near("sum3_q", out_q[63:48], sq[3] - sq[1]);
      end
      wr_reg(12'h210, 32'h4);
      repeat (60) @(posedge clk);
      #1 near("route_off", out_i[15:0], si[0] + si[1]);
      // step the own sample and watch for the fixed added delay
      @(posedge clk);
      in_i[15:0] <= si[0][15:0] - 16'h0800;
      repeat (52) @(posedge clk);
      #1 near("lat_old", out_i[15:0], si[0] + si[1]);
      @(posedge clk);
      #1 near("lat_new", out_i[15:0], si[0] - 2048 + si[1]);
      // own and routed samples near full scale force the sum out of range
      in_i[31:0] <= {16'h7000, 16'h7000};
      wr_reg(`ORA_A_IMSK, 32'h1);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
      if (irq !== 1'b1) begin
         fail_count++;
         stop_test;
      end
      repeat (60) @(posedge clk); // the summed path is 52 samples long
      #1 check("clamp_i", out_i[15:0], 16'h7FFF);
      check("dac_full", dac_full, 1'b1);
      rd_reg(`ORA_A_OVF, w);
      check("clamp_bit", w[16], 1'b1);
      rd_reg(`ORA_A_IST, v);
      check("ovf_event", v[0], 1'b1);
      rd_reg(`ORA_A_OVF, v);
      check("count_up", v[15:0] > w[15:0], 1'b1);
      wr_reg(`ORA_A_IMSK, 32'h0);
      #1 check("irq_mask", irq, 1'b0);
      wr_reg(`ORA_A_IMSK, 32'h1);
      wr_reg(`ORA_A_CTRL, 32'h0);
      repeat (70) @(posedge clk);
      rd_reg(`ORA_A_IST, v);
      rd_reg(`ORA_A_IST, v);
      check("ist_clear", v, 96'h0);
      wr_reg(`ORA_A_OVF, 32'h0);
      rd_reg(`ORA_A_OVF, v);
      check("ovf_clear", v, 96'h0);
      #1 check("irq_low", irq, 1'b0);
      stop_test;
   end
endmodule
